// >>> pis_pkg.sv
// package of constants and types for the two-wire slave interface
package pis_pkg;

   // ****************************************
   // clock and filter timing
   // ****************************************
   localparam int CLK_MHZ = 40;
   // spike width suppressed in the ordinary (up to 1MHz) range, in ns
   localparam int FS_SPIKE_NS = 50;
   // spike width suppressed in the high-speed range, in ns
   localparam int HS_SPIKE_NS = 10;
   localparam int FS_RAW_CYC = (FS_SPIKE_NS * CLK_MHZ + 999) / 1000;
   localparam int HS_RAW_CYC = (HS_SPIKE_NS * CLK_MHZ + 999) / 1000;
   // never less than one cycle of filtering
   localparam logic [2:0] FS_FILT_CYC = (FS_RAW_CYC < 1) ? 3'h1 : 3'(FS_RAW_CYC);
   localparam logic [2:0] HS_FILT_CYC = (HS_RAW_CYC < 1) ? 3'h1 : 3'(HS_RAW_CYC);

   // ****************************************
   // slave addresses and codes
   // ****************************************
   localparam logic [6:0] MAIN_ADDR_0 = 7'h40;
   localparam logic [6:0] MAIN_ADDR_1 = 7'h48;
   localparam logic [6:0] MAIN_ADDR_2 = 7'h44;
   localparam logic [6:0] MAIN_ADDR_3 = 7'h4c;
   localparam logic [6:0] TEST_ADDR = 7'h49;
   localparam logic [7:0] GEN_CALL_BYTE = 8'h00;
   // high-speed master code is 0000_1xxx: top five bits fixed
   localparam logic [4:0] HS_CODE_TOP = 5'h01;

   // ****************************************
   // framing and reset values
   // ****************************************
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [7:0] PTR_RESET = 8'h00;
   localparam logic LINE_IDLE = 1'b1;

   // ****************************************
   // state types
   // ****************************************
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RECV,
      ST_ACK,
      ST_SEND,
      ST_MACK,
      ST_IGNORE
   } pis_state_t;

   typedef enum logic [1:0] {
      PH_ADDR,
      PH_PTR,
      PH_WDATA
   } pis_phase_t;

endpackage : pis_pkg

// >>> pis_line_filter.sv
// spike filter for one bus line, with a selectable length
`timescale 1ns/10ps
module pis_line_filter (
   input wire logic clock,
   input wire logic nrst,
   input wire logic line_in,
   input wire logic hs_sel,
   output logic line_out
);

   logic [2:0] cnt_reg;
   logic [2:0] cnt_next;
   logic out_reg;
   logic out_next;
   logic [2:0] limit;

   // the output follows the input only once it has differed for the full length
   always_comb begin
      limit = hs_sel ? pis_pkg::HS_FILT_CYC : pis_pkg::FS_FILT_CYC;
      out_next = out_reg;
      cnt_next = 3'h0;
      if (line_in != out_reg) begin
         cnt_next = cnt_reg + 3'h1;
         if (cnt_next >= limit) begin
            out_next = line_in;
            cnt_next = 3'h0;
         end
      end
   end

   // lines idle high, so the filter starts high
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cnt_reg <= 3'h0;
         out_reg <= pis_pkg::LINE_IDLE;
      end else begin
         cnt_reg <= cnt_next;
         out_reg <= out_next;
      end
   end

   assign line_out = out_reg;

endmodule : pis_line_filter

// >>> pis_cond_detect.sv
// edge and start/stop condition detector on the filtered bus lines
`timescale 1ns/10ps
module pis_cond_detect (
   input wire logic clock,
   input wire logic nrst,
   input wire logic scl_f,
   input wire logic sda_f,
   output logic scl_rise,
   output logic scl_fall,
   output logic start_det,
   output logic stop_det
);

   logic scl_prev_reg;
   logic sda_prev_reg;
   logic scl_prev_next;
   logic sda_prev_next;

   // previous line values
   always_comb begin
      scl_prev_next = scl_f;
      sda_prev_next = sda_f;
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         scl_prev_reg <= pis_pkg::LINE_IDLE;
         sda_prev_reg <= pis_pkg::LINE_IDLE;
      end else begin
         scl_prev_reg <= scl_prev_next;
         sda_prev_reg <= sda_prev_next;
      end
   end

   // data moving while the clock stays high is a control condition
   assign scl_rise = scl_f & ~scl_prev_reg;
   assign scl_fall = ~scl_f & scl_prev_reg;
   assign start_det = scl_f & scl_prev_reg & sda_prev_reg & ~sda_f;
   assign stop_det = scl_f & scl_prev_reg & ~sda_prev_reg & sda_f;

endmodule : pis_cond_detect

// >>> pis_i2c_slave.sv
// two-wire serial slave interface: framing, addressing, acknowledge, filters
//
// Function
// - one bit per clock, data stable high
// - data change during clock high is control
// - nine-bit packets, eight data msb first
// - lines idle high; start is data fall
// - stop is data rise; returns idle
// - repeated start behaves as plain start
// - acknowledge drives data low ninth clock
// - not-acknowledge leaves data released high
// - every register pointer value is acknowledged
// - seven-bit address then direction bit
// - otp option picks one main address
// - foreign slave addresses are not acknowledged
// - test address acknowledged only when unlocked
// - clock line never driven, input only
// - general call byte is not acknowledged
// - no response to device-id query
// - any clock rate, no minimum frequency
// - filters reset to normal range, stop too
// - high-speed filters only after master code
// - master code not acknowledged, enables fast
// - repeated start keeps the filter setting
// - stop leaves the register pointer unchanged
`timescale 1ns/10ps
module pis_i2c_slave (
   input wire logic clock,
   input wire logic nrst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic [1:0] otp_addr_sel,
   input wire logic test_unlock,
   output logic hs_mode,
   output logic bus_busy,
   output logic wr_valid,
   output logic [7:0] wr_ptr,
   output logic [7:0] wr_data,
   output logic rd_strobe,
   output logic [7:0] rd_ptr,
   input wire logic [7:0] rd_data
);

   // ****************************************
   // helper functions
   // ****************************************

   // main address chosen by the factory option
   function automatic logic [6:0] main_addr(input logic [1:0] sel);
      logic [6:0] a;
      a = pis_pkg::MAIN_ADDR_0;
      if (sel == 2'h1) begin
         a = pis_pkg::MAIN_ADDR_1;
      end else if (sel == 2'h2) begin
         a = pis_pkg::MAIN_ADDR_2;
      end else if (sel == 2'h3) begin
         a = pis_pkg::MAIN_ADDR_3;
      end
      return a;
   endfunction : main_addr

   // pointer wraps over the full 8-bit space
   function automatic logic [7:0] ptr_inc(input logic [7:0] p);
      return p + 8'h01;
   endfunction : ptr_inc

   // ****************************************
   // line filters and condition detection
   // ****************************************

   logic scl_f;
   logic sda_f;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic hs_reg;

   // both lines share one filter length so their relative timing holds
   pis_line_filter u_scl_filt (
      .clock(clock),
      .nrst(nrst),
      .line_in(scl_in),
      .hs_sel(hs_reg),
      .line_out(scl_f)
   );

   pis_line_filter u_sda_filt (
      .clock(clock),
      .nrst(nrst),
      .line_in(sda_in),
      .hs_sel(hs_reg),
      .line_out(sda_f)
   );

   pis_cond_detect u_cond (
      .clock(clock),
      .nrst(nrst),
      .scl_f(scl_f),
      .sda_f(sda_f),
      .scl_rise(scl_rise),
      .scl_fall(scl_fall),
      .start_det(start_det),
      .stop_det(stop_det)
   );

   // ****************************************
   // protocol state
   // ****************************************

   pis_pkg::pis_state_t state_reg;
   pis_pkg::pis_state_t state_next;
   pis_pkg::pis_phase_t phase_reg;
   pis_pkg::pis_phase_t phase_next;
   logic [7:0] shift_reg;
   logic [7:0] shift_next;
   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;
   logic ack_reg;
   logic ack_next;
   logic [7:0] ptr_reg;
   logic [7:0] ptr_next;
   logic hs_next;
   logic oe_reg;
   logic oe_next;
   logic busy_reg;
   logic busy_next;
   logic wr_valid_reg;
   logic wr_valid_next;
   logic [7:0] wr_ptr_reg;
   logic [7:0] wr_ptr_next;
   logic [7:0] wr_data_reg;
   logic [7:0] wr_data_next;
   logic rd_strobe_reg;
   logic rd_strobe_next;
   logic addr_hit;
   logic hs_code;

   // address byte sits in shift_reg once eight bits are in
   always_comb begin
      addr_hit = (shift_reg[7:1] == main_addr(otp_addr_sel));
      if (test_unlock && shift_reg[7:1] == pis_pkg::TEST_ADDR) begin
         addr_hit = 1'b1;
      end
      // general call and device-id bytes never match, so they stay released
      if (shift_reg == pis_pkg::GEN_CALL_BYTE) begin
         addr_hit = 1'b0;
      end
      hs_code = (shift_reg[7:3] == pis_pkg::HS_CODE_TOP);
   end

   // next-state logic; a stop beats a start beats bit traffic
   always_comb begin
      state_next = state_reg;
      phase_next = phase_reg;
      shift_next = shift_reg;
      cnt_next = cnt_reg;
      ack_next = ack_reg;
      ptr_next = ptr_reg;
      hs_next = hs_reg;
      oe_next = oe_reg;
      busy_next = busy_reg;
      wr_valid_next = 1'b0;
      wr_ptr_next = wr_ptr_reg;
      wr_data_next = wr_data_reg;
      rd_strobe_next = 1'b0;
      if (stop_det) begin
         // pointer deliberately left alone
         state_next = pis_pkg::ST_IDLE;
         hs_next = 1'b0;
         oe_next = 1'b0;
         busy_next = 1'b0;
      end else if (start_det) begin
         // repeated start takes this same path and keeps hs_reg
         state_next = pis_pkg::ST_RECV;
         phase_next = pis_pkg::PH_ADDR;
         cnt_next = 4'h0;
         oe_next = 1'b0;
         busy_next = 1'b1;
      end else begin
         case (state_reg)
            pis_pkg::ST_RECV: begin
               if (scl_rise) begin
                  // sample while clock is high, msb first
                  shift_next = {shift_reg[6:0], sda_f};
                  cnt_next = cnt_reg + 4'h1;
               end else if (scl_fall && cnt_reg == pis_pkg::BITS_PER_BYTE) begin
                  cnt_next = 4'h0;
                  state_next = pis_pkg::ST_ACK;
                  ack_next = 1'b1;
                  if (phase_reg == pis_pkg::PH_ADDR) begin
                     ack_next = addr_hit;
                     if (hs_code) begin
                        hs_next = 1'b1;
                     end
                  end else if (phase_reg == pis_pkg::PH_WDATA) begin
                     wr_valid_next = 1'b1;
                     wr_ptr_next = ptr_reg;
                     wr_data_next = shift_reg;
                  end
                  // pointer and data bytes always acked, any value
                  oe_next = (phase_reg == pis_pkg::PH_ADDR) ? addr_hit : 1'b1;
               end
            end
            pis_pkg::ST_ACK: begin
               if (scl_fall) begin
                  oe_next = 1'b0;
                  state_next = pis_pkg::ST_RECV;
                  if (phase_reg == pis_pkg::PH_ADDR) begin
                     if (!ack_reg) begin
                        state_next = pis_pkg::ST_IGNORE;
                     end else if (shift_reg[0]) begin
                        // read: first data bit must be on the line now
                        // pointer held, so a re-read after stop finds this register
                        shift_next = rd_data;
                        rd_strobe_next = 1'b1;
                        oe_next = ~rd_data[7];
                        state_next = pis_pkg::ST_SEND;
                     end else begin
                        phase_next = pis_pkg::PH_PTR;
                     end
                  end else if (phase_reg == pis_pkg::PH_PTR) begin
                     ptr_next = shift_reg;
                     phase_next = pis_pkg::PH_WDATA;
                  end else begin
                     ptr_next = ptr_inc(ptr_reg);
                  end
               end
            end
            pis_pkg::ST_SEND: begin
               // new bit only after the falling edge keeps data stable high
               if (scl_fall) begin
                  cnt_next = cnt_reg + 4'h1;
                  if (cnt_reg == pis_pkg::BITS_PER_BYTE - 4'h1) begin
                     cnt_next = 4'h0;
                     oe_next = 1'b0;
                     state_next = pis_pkg::ST_MACK;
                  end else begin
                     shift_next = {shift_reg[6:0], 1'b0};
                     oe_next = ~shift_reg[6];
                  end
               end
            end
            pis_pkg::ST_MACK: begin
               if (scl_rise) begin
                  ack_next = ~sda_f;
                  // step on the master acknowledge so rd_data settles before the fall
                  if (!sda_f) begin
                     ptr_next = ptr_inc(ptr_reg);
                  end
               end else if (scl_fall) begin
                  if (ack_reg) begin
                     shift_next = rd_data;
                     rd_strobe_next = 1'b1;
                     oe_next = ~rd_data[7];
                     state_next = pis_pkg::ST_SEND;
                  end else begin
                     // master is finishing; wait for stop or repeated start
                     state_next = pis_pkg::ST_IGNORE;
                  end
               end
            end
            default: begin
               // idle and ignore only leave on a start or stop
               state_next = state_reg;
            end
         endcase
      end
   end

   // register the protocol state; filters start in the normal range
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_reg <= pis_pkg::ST_IDLE;
         phase_reg <= pis_pkg::PH_ADDR;
         shift_reg <= 8'h00;
         cnt_reg <= 4'h0;
         ack_reg <= 1'b0;
         ptr_reg <= pis_pkg::PTR_RESET;
         hs_reg <= 1'b0;
         oe_reg <= 1'b0;
         busy_reg <= 1'b0;
         wr_valid_reg <= 1'b0;
         wr_ptr_reg <= 8'h00;
         wr_data_reg <= 8'h00;
         rd_strobe_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         phase_reg <= phase_next;
         shift_reg <= shift_next;
         cnt_reg <= cnt_next;
         ack_reg <= ack_next;
         ptr_reg <= ptr_next;
         hs_reg <= hs_next;
         oe_reg <= oe_next;
         busy_reg <= busy_next;
         wr_valid_reg <= wr_valid_next;
         wr_ptr_reg <= wr_ptr_next;
         wr_data_reg <= wr_data_next;
         rd_strobe_reg <= rd_strobe_next;
      end
   end

   // ****************************************
   // outputs
   // ****************************************

   // open drain: only ever pulls low; there is no clock output at all
   assign sda_out = 1'b0;
   assign sda_oe = oe_reg;
   assign hs_mode = hs_reg;
   assign bus_busy = busy_reg;
   assign wr_valid = wr_valid_reg;
   assign wr_ptr = wr_ptr_reg;
   assign wr_data = wr_data_reg;
   assign rd_strobe = rd_strobe_reg;
   // the register file must present rd_data for rd_ptr combinationally
   assign rd_ptr = ptr_reg;

endmodule : pis_i2c_slave

// >>> pis_i2c_slave_chk.sv
// port checker of the two-wire slave interface
`timescale 1ns/10ps
module pis_i2c_slave_chk (
   input wire logic clock,
   input wire logic nrst,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_oe,
   input wire logic hs_mode,
   input wire logic bus_busy,
   input wire logic wr_valid,
   input wire logic rd_strobe,
   input wire logic [7:0] rd_ptr,
   input wire logic [7:0] rd_data
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   // ******
   // bus line relations
   // ******
   oe_busy_a: assert property (sda_oe |-> bus_busy)
      else $error("data line pulled while bus idle");
   // data may only move while the clock is low, else a stop or start is faked
   oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("data line changed with clock high");
   start_seen_a: assert property ($rose(bus_busy) |-> scl_in && !sda_in)
      else $error("busy rose without a start");
   stop_seen_a: assert property ($fell(bus_busy) |-> scl_in && sda_in)
      else $error("busy fell without a stop");
   idle_release_a: assert property ((!bus_busy)[*2] |-> !sda_oe && !hs_mode)
      else $error("line or fast filter held after stop");
   hs_nack_a: assert property ($rose(hs_mode) |-> (bus_busy && !sda_oe)[*8])
      else $error("master code acknowledged");
   wr_ack_a: assert property (wr_valid |-> sda_oe && !scl_in ##1 !wr_valid)
      else $error("write byte not acknowledged");
   // the pointer steps on the master acknowledge, never at the load itself
   rd_load_a: assert property (rd_strobe |-> sda_oe == !$past(rd_data[7]) &&
      rd_ptr == $past(rd_ptr))
      else $error("read byte msb wrong or pointer moved at load");
   ptr_keep_a: assert property ($fell(bus_busy) |-> $stable(rd_ptr))
      else $error("pointer changed at stop");
   cover property (wr_valid);
   cover property (rd_strobe);
   cover property ($rose(hs_mode));
endmodule : pis_i2c_slave_chk
bind pis_i2c_slave pis_i2c_slave_chk chk_i (.clock(clock), .nrst(nrst), .scl_in(scl_in),
   .sda_in(sda_in), .sda_oe(sda_oe), .hs_mode(hs_mode), .bus_busy(bus_busy),
   .wr_valid(wr_valid), .rd_strobe(rd_strobe), .rd_ptr(rd_ptr), .rd_data(rd_data));

// >>> pis_bus_master.sv
// behavioural bus master model driving the slave's bus lines
`timescale 1ns/10ps
module pis_bus_master (
   input wire logic clock,
   input wire logic sda_in,
   output logic scl,
   output logic sda_m
);
   // quarter bit in clocks: 10 is 1MHz, less only after the master code
   int q = 10;
   // both lines released high while idle; the clock stands still
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   task automatic wt();
      repeat (q) @(negedge clock);
   endtask : wt
   // one bit: data set in the low phase, sampled mid high phase
   task automatic bit_x(input logic d, output logic s);
      wt();
      sda_m = d;
      wt();
      scl = 1'b1;
      wt();
      s = sda_in;
      wt();
      scl = 1'b0;
   endtask : bit_x
   // start or repeated start, no preamble at normal speed
   task automatic start();
      wt();
      sda_m = 1'b1;
      wt();
      scl = 1'b1;
      wt();
      sda_m = 1'b0;
      wt();
      scl = 1'b0;
   endtask : start
   task automatic stop();
      wt();
      sda_m = 1'b0;
      wt();
      scl = 1'b1;
      wt();
      sda_m = 1'b1;
      wt();
   endtask : stop
   // eight bits msb first, then the line released for the answer
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(b[i], s);
      end
      bit_x(1'b1, s);
      ack = !s;
   endtask : wbyte
   // mack low gives the closing not-acknowledge
   task automatic rbyte(input logic mack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, b[i]);
      end
      bit_x(!mack, s);
   endtask : rbyte
endmodule : pis_bus_master

// >>> tb.sv
// self-checking testbench of the two-wire slave interface
`timescale 1ns/10ps
module tb;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic [1:0] otp_addr_sel = 2'h0;
   logic test_unlock = 1'b0;
   logic scl, sda_m, sda_oe, sda_out, hs_mode, bus_busy, wr_valid, rd_strobe, a;
   logic [7:0] wr_ptr, wr_data, rd_ptr, rd_data, p, d, b, wp, wd;
   wire sda;
   int errors = 0;
   int num_checks = 0;
   int nrd = 0;
   int seed = 32'h42c36463;
   logic [7:0] rb [5] = '{8'h92, 8'h92, 8'h00, 8'hf8, 8'h00};
   logic ru [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
   logic ra [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
   // open drain: pulled up unless a party pulls low
   assign sda = sda_m & (sda_oe ? sda_out : 1'b1);
   // register stand-in derived from the pointer
   assign rd_data = rd_ptr ^ 8'h5a;
   always #12.5 clock = ~clock;
   pis_i2c_slave dut (.clock(clock), .nrst(nrst), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .otp_addr_sel(otp_addr_sel),
      .test_unlock(test_unlock), .hs_mode(hs_mode), .bus_busy(bus_busy),
      .wr_valid(wr_valid), .wr_ptr(wr_ptr), .wr_data(wr_data), .rd_strobe(rd_strobe),
      .rd_ptr(rd_ptr), .rd_data(rd_data));
   pis_bus_master m (.clock(clock), .sda_in(sda), .scl(scl), .sda_m(sda_m));
   // keep the last write handed over and count read loads, away from the launch edge
   always @(negedge clock) begin
      if (wr_valid === 1'b1) begin
         wp = wr_ptr;
         wd = wr_data;
      end
      if (rd_strobe === 1'b1) begin
         nrd++;
      end
   end
   function automatic logic [6:0] main_addr(input logic [1:0] s);
      case (s)
         2'h0: return 7'h40;
         2'h1: return 7'h48;
         2'h2: return 7'h44;
         default: return 7'h4c;
      endcase
   endfunction : main_addr
   function automatic logic [7:0] rexp(input logic [7:0] x);
      return x ^ 8'h5a;
   endfunction : rexp
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic send(input logic [7:0] v, input logic e);
      m.wbyte(v, a);
      chk("ack", {7'h0, a}, {7'h0, e});
   endtask : send
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_of_test
   // ******
   // scenarios
   // ******
   initial begin
      repeat (16) @(negedge clock);
      nrst = 1'b1;
      repeat (4) @(negedge clock);
      // write, read after repeated start, re-read after stop, every option
      for (int s = 0; s < 4; s++) begin
         otp_addr_sel = 2'(s);
         p = 8'($random(seed));
         d = 8'($random(seed));
         // first option at a slow pace: there is no minimum clock rate
         m.q = (s == 0) ? 40 : 10;
         m.start();
         send({main_addr(2'(s)), 1'b0}, 1'b1);
         send(p, 1'b1);
         send(d, 1'b1);
         chk("wr_ptr", wp, p);
         chk("wr_data", wd, d);
         chk("hs_mode", {7'h0, hs_mode}, 8'h0);
         m.start();
         send({main_addr(2'(s)), 1'b1}, 1'b1);
         m.rbyte(1'b0, b);
         chk("rd_byte", b, rexp(p + 8'h1));
         m.stop();
         chk("bus_busy", {7'h0, bus_busy}, 8'h0);
         chk("rd_ptr_stop", rd_ptr, p + 8'h1);
         m.start();
         send({main_addr(2'(s)), 1'b1}, 1'b1);
         m.rbyte(1'b1, b);
         chk("rd_again", b, rexp(p + 8'h1));
         m.rbyte(1'b0, b);
         chk("rd_next", b, rexp(p + 8'h2));
         m.stop();
         chk("rd_ptr_end", rd_ptr, p + 8'h2);
         $display("test option %0d done", s);
      end
      m.q = 10;
      // three loads per option: first read, re-read and the next byte after the acknowledged re-read
      chk("rd_strobes", 8'(nrd), 8'hc);
      // test, general call, device-id and random foreign addresses
      rb[4] = {1'b0, 6'($random(seed)), 1'b0};
      for (int i = 0; i < 5; i++) begin
         test_unlock = ru[i];
         m.start();
         send(rb[i], ra[i]);
         send(8'h00, ra[i]);
         m.stop();
         // after a refused transfer the main address write byte must still be acknowledged
         if (!ra[i]) begin
            m.start();
            send({main_addr(otp_addr_sel), 1'b0}, 1'b1);
            m.stop();
         end
      end
      $display("test foreign addresses done");
      // master code, faster pace after repeated start, stop restores
      test_unlock = 1'b0;
      d = 8'($random(seed));
      m.start();
      send({5'h01, 3'($random(seed))}, 1'b0);
      chk("hs_on", {7'h0, hs_mode}, 8'h1);
      m.q = 4;
      m.start();
      send({main_addr(otp_addr_sel), 1'b0}, 1'b1);
      send(p, 1'b1);
      send(d, 1'b1);
      chk("hs_ptr", wp, p);
      chk("hs_wr", wd, d);
      chk("hs_keep", {7'h0, hs_mode}, 8'h1);
      m.q = 10;
      m.stop();
      chk("hs_off", {7'h0, hs_mode}, 8'h0);
      $display("test high speed done");
      end_of_test();
   end
   // watchdog well beyond the expected run of some 30000 cycles
   initial begin
      repeat (60000) @(posedge clock);
      errors++;
      end_of_test();
   end
endmodule : tb
